// File: backlight_dimming_config_regs.sv
// Dimming configuration registers of a six-string backlight driver, channels 1 and 2 on-time.
// Assumes a serial front end on sys_clk giving one-cycle read and write strobes.
`timescale 1ns/10ps
`include "backlight_dim_defs.svh"

module backlight_dimming_config_regs
  import backlight_dim_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic extDimPin,
  input wire logic [3:0] lowBrightness,
  input wire logic periodStart,
  output dim_cfg_t dimCfg,
  output logic extDimLevel,
  output logic [3:0] stringCurrentCode,
  output logic [7:0] stringCurrentMa,
  output on_time_t ch1OnTimeValue,
  output on_time_t ch2OnTimeValue
);
  // On-time LSB weighs 50ns, not a whole number of 4ns cycles

  logic [3:0] currentCode_q;
  dim_cfg_t cfg_q;
  logic [7:0] ch1High_q, ch1Mid_q, ch2High_q, ch2Mid_q;
  logic [3:0] lsbPair_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  on_time_t ch1Applied_q, ch2Applied_q;
  on_time_t ch1Staged, ch2Staged;
  logic dimSync1_q, dimSync2_q;
  logic [7:0] stringMa_q;

  wire logic wrStrobe = clkEn && regWrite;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      currentCode_q <= `RST_CURRENT_CODE;
    end else if (wrStrobe && regAddr == `OFS_CURRENT_SET) begin
      currentCode_q <= regWdata[3:0];
    end
  end

  // Current in mA; widest value 120 fits 8 bits
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stringMa_q <= 8'h00;
    end else if (clkEn) begin
      stringMa_q <= 8'(`CURRENT_BASE_MA) + 8'(currentCode_q) * 8'(`CURRENT_STEP_MA);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg_q.externalDimSelect <= `RST_EXT_SELECT;
      cfg_q.hybridDimEnable <= `RST_HYBRID;
      cfg_q.hybridCrossoverThreshold <= `RST_THRESHOLD;
    end else if (wrStrobe && regAddr == `OFS_DIM_MODE) begin
      // Status bits 7..4 are not storage; writes to them vanish
      cfg_q.externalDimSelect <= regWdata[`BIT_EXT_SELECT];
      cfg_q.hybridDimEnable <= regWdata[`BIT_HYBRID];
      cfg_q.hybridCrossoverThreshold <= regWdata[1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ch1High_q <= `RST_CH1_HIGH;
      ch1Mid_q <= `RST_CH1_MID;
      ch2High_q <= `RST_CH2_HIGH;
      ch2Mid_q <= `RST_CH2_MID;
      lsbPair_q <= {`RST_LSB_PAIR, `RST_LSB_PAIR};
    end else if (wrStrobe) begin
      case (regAddr)
        `OFS_CH1_HIGH: ch1High_q <= regWdata;
        `OFS_CH1_MID: ch1Mid_q <= regWdata;
        `OFS_CH2_HIGH: ch2High_q <= regWdata;
        `OFS_CH2_MID: ch2Mid_q <= regWdata;
        `OFS_ON_TIME_LSB: lsbPair_q <= regWdata[3:0];
        default: ;
      endcase
    end
  end

  assign ch1Staged = {ch1High_q, ch1Mid_q, lsbPair_q[`LSB_CH1_MSB -: 2]};
  assign ch2Staged = {ch2High_q, ch2Mid_q, lsbPair_q[`LSB_CH2_MSB -: 2]};

  // Held until the period edge so a byte-by-byte update never tears a pulse
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ch1Applied_q <= {`RST_CH1_HIGH, `RST_CH1_MID, `RST_LSB_PAIR};
      ch2Applied_q <= {`RST_CH2_HIGH, `RST_CH2_MID, `RST_LSB_PAIR};
    end else if (clkEn && periodStart) begin
      ch1Applied_q <= ch1Staged;
      ch2Applied_q <= ch2Staged;
    end
  end

  // Pin is asynchronous; only the second flop feeds logic
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dimSync1_q <= 1'b0;
      dimSync2_q <= 1'b0;
    end else if (clkEn) begin
      dimSync1_q <= extDimPin;
      dimSync2_q <= dimSync1_q;
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    case (regAddr)
      `OFS_CURRENT_SET: rdata_d = {4'h0, currentCode_q};
      `OFS_DIM_MODE: rdata_d = {lowBrightness, cfg_q.externalDimSelect,
                                cfg_q.hybridDimEnable, cfg_q.hybridCrossoverThreshold};
      `OFS_CH1_HIGH: rdata_d = ch1High_q;
      `OFS_CH1_MID: rdata_d = ch1Mid_q;
      `OFS_CH2_HIGH: rdata_d = ch2High_q;
      `OFS_CH2_MID: rdata_d = ch2Mid_q;
      `OFS_ON_TIME_LSB: rdata_d = {4'h0, lsbPair_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (clkEn && regRead) begin
      rdata_q <= rdata_d;
    end
  end

  assign regRdata = rdata_q;
  assign dimCfg = cfg_q;
  // Low output when dimming comes from the on-time registers
  assign extDimLevel = cfg_q.externalDimSelect & dimSync2_q;
  assign stringCurrentCode = currentCode_q;
  assign stringCurrentMa = stringMa_q;
  assign ch1OnTimeValue = ch1Applied_q;
  assign ch2OnTimeValue = ch2Applied_q;

  sequence wrAt(logic [7:0] ofs);
    clkEn && regWrite && regAddr == ofs;
  endsequence

  sequence rdAt(logic [7:0] ofs);
    clkEn && regRead && regAddr == ofs;
  endsequence

  current_map_a: assert property (@(posedge sys_clk) disable iff (reset)
    clkEn |=> !clkEn || stringCurrentMa == 8'(45 + 5 * $past(currentCode_q)))
    else $error("string current not linear in code");

  low_flags_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    rdAt(`OFS_DIM_MODE) |=> regRdata[7:4] == $past(lowBrightness))
    else $error("low-dim flags misreported");

  ext_select_a: assert property (@(posedge sys_clk) disable iff (reset)
    wrAt(`OFS_DIM_MODE) |=> dimCfg.externalDimSelect == $past(regWdata[3]) &&
      (dimCfg.externalDimSelect || !extDimLevel))
    else $error("external dim select wrong");

  hybrid_enable_a: assert property (@(posedge sys_clk) disable iff (reset)
    wrAt(`OFS_DIM_MODE) |=> dimCfg.hybridDimEnable == $past(regWdata[2]))
    else $error("hybrid enable not taken");

  threshold_field_a: assert property (@(posedge sys_clk) disable iff (reset)
    wrAt(`OFS_DIM_MODE) ##1 rdAt(`OFS_DIM_MODE) |=>
      regRdata[1:0] == $past(regWdata[1:0], 2))
    else $error("threshold readback wrong");

  ch1_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !(clkEn && periodStart) |=> $stable(ch1OnTimeValue) && $stable(ch2OnTimeValue))
    else $error("on-time changed outside period edge");

  ch1_assembly_a: assert property (@(posedge sys_clk) disable iff (reset)
    clkEn && periodStart |=> ch1OnTimeValue[17:10] == $past(ch1High_q) &&
      ch1OnTimeValue[9:2] == $past(ch1Mid_q) && ch1OnTimeValue[1:0] == $past(lsbPair_q[1:0]))
    else $error("channel 1 on-time mis-assembled");

  ch2_assembly_a: assert property (@(posedge sys_clk) disable iff (reset)
    wrAt(`OFS_CH2_HIGH) ##1 (clkEn && periodStart && !regWrite) |=>
      ch2OnTimeValue[17:10] == $past(regWdata, 2))
    else $error("channel 2 high byte not applied");

  lsb_pair_a: assert property (@(posedge sys_clk) disable iff (reset)
    wrAt(`OFS_ON_TIME_LSB) ##1 rdAt(`OFS_ON_TIME_LSB) |=>
      regRdata == {4'h0, $past(regWdata[3:0], 2)})
    else $error("shared lsb register wrong");

  code_freeze_a: assert property (@(posedge sys_clk) disable iff (reset)
    !clkEn |=> $stable(stringCurrentCode) && $stable(stringCurrentMa))
    else $error("current setting moved while clock enable low");

  current_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    rdAt(`OFS_CURRENT_SET) |=> regRdata == {4'h0, $past(stringCurrentCode)})
    else $error("current code readback wrong");

  dim_pin_sync_a: assert property (@(posedge sys_clk) disable iff (reset)
    clkEn ##1 clkEn |=>
      extDimLevel == (dimCfg.externalDimSelect && $past(extDimPin, 2)))
    else $error("external dim level not two synchronised edges behind pin");

  lsb_upper_zero_a: assert property (@(posedge sys_clk) disable iff (reset)
    rdAt(`OFS_ON_TIME_LSB) |=> regRdata[7:4] == 4'h0)
    else $error("unused lsb register bits read nonzero");
endmodule

// File: backlight_dim_defs.svh
// Offsets, field positions, reset values and timing figures of the dimming config slice.
// Assumes byte-wide registers on an 8-bit register address.
`ifndef BACKLIGHT_DIM_DEFS_SVH
`define BACKLIGHT_DIM_DEFS_SVH
`define OFS_CURRENT_SET 8'h02
`define OFS_DIM_MODE 8'h03
`define OFS_CH1_HIGH 8'h04
`define OFS_CH1_MID 8'h05
`define OFS_CH2_HIGH 8'h06
`define OFS_CH2_MID 8'h07
`define OFS_ON_TIME_LSB 8'h0c
`define RST_CURRENT_CODE 4'hb
`define RST_EXT_SELECT 1'h1
`define RST_HYBRID 1'h0
`define RST_THRESHOLD 2'h0
`define RST_CH1_HIGH 8'h7f
`define RST_CH1_MID 8'hff
`define RST_CH2_HIGH 8'h7f
`define RST_CH2_MID 8'h7f
`define RST_LSB_PAIR 2'h3
`define BIT_EXT_SELECT 3
`define BIT_HYBRID 2
`define LOW_FLAGS_MSB 7
`define LOW_FLAGS_LSB 4
`define LSB_CH1_MSB 1
`define LSB_CH2_MSB 3
`define CURRENT_BASE_MA 45
`define CURRENT_STEP_MA 5
`define ON_TIME_LSB_NS 50
`define SYS_CLK_PERIOD_NS 4
`endif

// File: backlight_dim_pkg.sv
// Types shared by the dimming config slice.
// Assumes the defs header supplies all numeric constants.
package backlight_dim_pkg;
  typedef logic [17:0] on_time_t;
  typedef struct packed {
    logic externalDimSelect;
    logic hybridDimEnable;
    logic [1:0] hybridCrossoverThreshold;
  } dim_cfg_t;
endpackage

// File: reg_host_model.sv
// Host model: byte writes and reads over the register strobe port.
// Assumes strobes are sampled on the rising edge of sys_clk.
`timescale 1ns/10ps
module reg_host_model (
  input wire logic sys_clk,
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata,
  input wire logic [7:0] regRdata
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  // Released lines are inverted so stale values never pass for valid ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge sys_clk);
    regWrite = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge sys_clk);
    regRead = 1'b0;
    regAddr = ~a;
    @(negedge sys_clk);
    d = regRdata;
  endtask
  // Write then read the same offset on the very next edge
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge sys_clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge sys_clk);
    regWrite = 1'b0;
    regRead = 1'b1;
    @(negedge sys_clk);
    regRead = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
    @(negedge sys_clk);
    q = regRdata;
  endtask
endmodule

// File: testbench.sv
// Self-checking bench for the dimming config registers.
// Assumes the host model drives the strobe port at falling edges.
`timescale 1ns/10ps
module testbench;
  import backlight_dim_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic extDimPin = 1'b1;
  logic [3:0] lowBrightness = 4'h0;
  logic periodStart = 1'b0;
  logic regWrite, regRead;
  logic [7:0] regAddr, regWdata, regRdata, rv, stringCurrentMa;
  logic [3:0] stringCurrentCode;
  logic extDimLevel;
  dim_cfg_t dimCfg;
  on_time_t ch1OnTimeValue, ch2OnTimeValue;
  logic clkEn = 1'b1;
  int errTotal = 0;
  int testsRun = 0;
  always #2 sys_clk = ~sys_clk;
  reg_host_model host (.sys_clk(sys_clk), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));
  backlight_dimming_config_regs dut (.sys_clk(sys_clk), .reset(reset), .clkEn(clkEn),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .extDimPin(extDimPin), .lowBrightness(lowBrightness),
    .periodStart(periodStart), .dimCfg(dimCfg), .extDimLevel(extDimLevel),
    .stringCurrentCode(stringCurrentCode), .stringCurrentMa(stringCurrentMa),
    .ch1OnTimeValue(ch1OnTimeValue), .ch2OnTimeValue(ch2OnTimeValue));
  task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk("read data", {10'h0, exp}, {10'h0, rv});
  endtask
  task automatic test_reset_values;
    rchk(8'h02, 8'h0b);
    rchk(8'h03, 8'h08);
    rchk(8'h04, 8'h7f);
    rchk(8'h05, 8'hff);
    rchk(8'h06, 8'h7f);
    rchk(8'h07, 8'h7f);
    rchk(8'h0c, 8'h0f);
    rchk(8'h20, 8'h00);
    chk("current mA", 18'd100, {10'h0, stringCurrentMa});
    $display("test reset values done");
  endtask
  task automatic test_current_codes;
    for (int i = 0; i < 16; i++) begin
      host.wr(8'h02, 8'(i));
      @(negedge sys_clk);
      chk("current mA", 18'(45 + 5 * i), {10'h0, stringCurrentMa});
      chk("current code", 18'(i), {14'h0, stringCurrentCode});
    end
    $display("test current codes done");
  endtask
  task automatic test_clock_enable;
    clkEn = 1'b0;
    host.wr(8'h02, 8'h03);
    clkEn = 1'b1;
    chk("current code", 18'hf, {14'h0, stringCurrentCode});
    rchk(8'h02, 8'h0f);
    $display("test clock enable done");
  endtask
  task automatic test_back_to_back;
    lowBrightness = 4'h5;
    host.wr_rd(8'h03, 8'h0e, rv);
    chk("mode readback", {10'h0, 8'h5e}, {10'h0, rv});
    host.wr_rd(8'h0c, 8'hf9, rv);
    chk("lsb readback", {10'h0, 8'h09}, {10'h0, rv});
    $display("test back to back done");
  endtask
  task automatic test_mode_bits;
    lowBrightness = 4'ha;
    for (int t = 0; t < 4; t++) begin
      host.wr(8'h03, {4'hf, 2'b01, 2'(t)});
      rchk(8'h03, {4'ha, 2'b01, 2'(t)});
      chk("mode cfg", {14'h0, 2'b01, 2'(t)}, {14'h0, dimCfg});
      chk("dim level", 18'h0, {17'h0, extDimLevel});
    end
    host.wr(8'h03, 8'h08);
    repeat (3) @(negedge sys_clk);
    chk("dim level", 18'h1, {17'h0, extDimLevel});
    extDimPin = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("dim level", 18'h0, {17'h0, extDimLevel});
    $display("test mode bits done");
  endtask
  task automatic test_on_time;
    host.wr(8'h04, 8'haa);
    host.wr(8'h05, 8'h55);
    host.wr(8'h0c, 8'h06);
    host.wr(8'h07, 8'h34);
    host.wr(8'h06, 8'h12);
    chk("ch1 on-time", {8'h7f, 8'hff, 2'b11}, ch1OnTimeValue);
    periodStart = 1'b1;
    @(negedge sys_clk);
    periodStart = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("ch1 on-time", {8'haa, 8'h55, 2'b10}, ch1OnTimeValue);
    chk("ch2 on-time", {8'h12, 8'h34, 2'b01}, ch2OnTimeValue);
    $display("test on-time done");
  endtask
  task automatic reportAndStop;
    $display("comparisons %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    test_reset_values;
    test_current_codes;
    test_clock_enable;
    test_mode_bits;
    test_back_to_back;
    test_on_time;
    reportAndStop;
  end
  // Run needs about 150 cycles; limit leaves ample margin
  initial begin
    #40000;
    errTotal++;
    reportAndStop;
  end
endmodule
